// [drcb_bank.sv]
// Drive command register bank: stores host command words and derives applied commands.
// Assumes the link front end delivers one validated write frame per wr_valid_in pulse.
//
// How it works
// - Per-unit reference is signed 16-bit; 20000 means maximum frequency, linear.
// - Non-zero per-unit reference wins over the hundredth-hertz reference.
// - Non-zero hundredth-hertz reference wins over the speed setpoint.
// - Reads return the last written word (zero for fault clear), never the applied value.
// - Writes above 20000 accepted; applied frequency clamped to max or upper limit.
// - Reduced variants apply a negative PID setpoint as zero, storing it unchanged.
// - Run word bit 15 one-then-zero resets alarms only when link route active.
// - Fault clear write of one raises reset for fixed time; reads zero.
`timescale 1ns/10ps
module drcb_bank #(
    parameter int FCLR_HOLD_CYCLES = drcb_pkg::FCLR_HOLD_CYCLES
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wr_valid_in,
    input wire logic [4:0] wr_code_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [4:0] rd_code_in,
    input wire logic link_route_select_in,
    input wire logic link_enable_input_in,
    input wire logic reduced_variant_in,
    input wire logic [15:0] pu_limit_in,
    input wire logic [15:0] hz_limit_in,
    output logic [15:0] rd_data_out,
    output logic rd_hit_out,
    output logic [15:0] run_word_out,
    output logic [15:0] digital_out_out,
    output logic [15:0] analog_out_out,
    output logic alarm_reset_out,
    output logic fault_reset_out,
    output drcb_pkg::drcb_src_t ref_source_out,
    output logic [15:0] applied_pu_out,
    output logic [15:0] applied_hz_out,
    output logic [15:0] applied_speed_out,
    output logic [15:0] applied_pid_out
);

    // ----------------------------------------------------------------
    // Code decode
    // ----------------------------------------------------------------
    function automatic logic [4:0] drcb_decode(input logic [4:0] code);
        logic [4:0] r;
        r = 5'h00;
        case (code)
            drcb_pkg::CODE_FREQ_PU: r = {1'b1, drcb_pkg::IDX_FREQ_PU};
            drcb_pkg::CODE_FREQ_HZ: r = {1'b1, drcb_pkg::IDX_FREQ_HZ};
            drcb_pkg::CODE_RUN: r = {1'b1, drcb_pkg::IDX_RUN};
            drcb_pkg::CODE_DOUT: r = {1'b1, drcb_pkg::IDX_DOUT};
            drcb_pkg::CODE_ACCEL: r = {1'b1, drcb_pkg::IDX_ACCEL};
            drcb_pkg::CODE_DECEL: r = {1'b1, drcb_pkg::IDX_DECEL};
            drcb_pkg::CODE_TRQ1: r = {1'b1, drcb_pkg::IDX_TRQ1};
            drcb_pkg::CODE_TRQ2: r = {1'b1, drcb_pkg::IDX_TRQ2};
            drcb_pkg::CODE_AOUT: r = {1'b1, drcb_pkg::IDX_AOUT};
            drcb_pkg::CODE_PID: r = {1'b1, drcb_pkg::IDX_PID};
            drcb_pkg::CODE_FCLR: r = {1'b1, drcb_pkg::IDX_FCLR};
            drcb_pkg::CODE_SPEED: r = {1'b1, drcb_pkg::IDX_SPEED};
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    logic [4:0] wr_dec;
    logic [4:0] rd_dec;
    logic wr_hit;
    logic link_active;
    logic fclr_write;
    logic run_write;
    logic [15:0] words_ff [0:drcb_pkg::NWORDS-1];
    logic [31:0] fclr_cnt_ff;

    assign wr_dec = drcb_decode(wr_code_in);
    assign rd_dec = drcb_decode(rd_code_in);
    assign wr_hit = wr_valid_in && wr_dec[4];
    assign link_active = link_route_select_in && link_enable_input_in;
    assign fclr_write = wr_hit && (wr_dec[3:0] == drcb_pkg::IDX_FCLR);
    assign run_write = wr_hit && (wr_dec[3:0] == drcb_pkg::IDX_RUN);

    // ----------------------------------------------------------------
    // Word storage
    // ----------------------------------------------------------------
    // The fault clear word is never stored, so its slot stays zero for reads.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < drcb_pkg::NWORDS; i++) begin
                words_ff[i] <= drcb_pkg::WORD_RESET;
            end
        end else if (wr_hit && !fclr_write) begin
            words_ff[wr_dec[3:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= 16'h0000;
            rd_hit_out <= 1'b0;
        end else begin
            rd_data_out <= rd_dec[4] ? words_ff[rd_dec[3:0]] : 16'h0000;
            rd_hit_out <= rd_dec[4];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_word_out <= 16'h0000;
            digital_out_out <= 16'h0000;
            analog_out_out <= 16'h0000;
        end else begin
            run_word_out <= words_ff[drcb_pkg::IDX_RUN];
            digital_out_out <= words_ff[drcb_pkg::IDX_DOUT];
            analog_out_out <= words_ff[drcb_pkg::IDX_AOUT];
        end
    end

    // ----------------------------------------------------------------
    // Alarm and fault reset paths
    // ----------------------------------------------------------------
    // Reset fires on the falling bit, so a host that leaves bit 15 set cannot retrigger.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            alarm_reset_out <= 1'b0;
        end else begin
            alarm_reset_out <= run_write && link_active && words_ff[drcb_pkg::IDX_RUN][drcb_pkg::RUN_RST_BIT]
                && !wr_data_in[drcb_pkg::RUN_RST_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fclr_cnt_ff <= 32'h00000000;
        end else if (fclr_write && (wr_data_in == drcb_pkg::FCLR_ACTIVE)) begin
            fclr_cnt_ff <= 32'(FCLR_HOLD_CYCLES);
        end else if (fclr_cnt_ff != 32'h00000000) begin
            fclr_cnt_ff <= fclr_cnt_ff - 32'h00000001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_reset_out <= 1'b0;
        end else begin
            fault_reset_out <= (fclr_write && (wr_data_in == drcb_pkg::FCLR_ACTIVE)) || (fclr_cnt_ff > 32'h00000001);
        end
    end

    // ----------------------------------------------------------------
    // Reference selection
    // ----------------------------------------------------------------
    drcb_ref_if ref_if ();

    assign ref_if.freq_pu = words_ff[drcb_pkg::IDX_FREQ_PU];
    assign ref_if.freq_hz = words_ff[drcb_pkg::IDX_FREQ_HZ];
    assign ref_if.speed = words_ff[drcb_pkg::IDX_SPEED];
    assign ref_if.pid = words_ff[drcb_pkg::IDX_PID];
    assign ref_if.reduced = reduced_variant_in;
    assign ref_if.pu_limit = pu_limit_in;
    assign ref_if.hz_limit = hz_limit_in;
    assign ref_source_out = ref_if.src;
    assign applied_pu_out = ref_if.applied_pu;
    assign applied_hz_out = ref_if.applied_hz;
    assign applied_speed_out = ref_if.applied_speed;
    assign applied_pid_out = ref_if.applied_pid;

    drcb_ref_sel u_sel (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ref_if(ref_if.sel)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_fclr_hit;
        fclr_write && (wr_data_in == drcb_pkg::FCLR_ACTIVE);
    endsequence
    sequence s_rst_fall;
        run_write && link_active && words_ff[drcb_pkg::IDX_RUN][drcb_pkg::RUN_RST_BIT]
            && !wr_data_in[drcb_pkg::RUN_RST_BIT];
    endsequence

    property p_pu_wins;
        (words_ff[drcb_pkg::IDX_FREQ_PU] != 16'h0000) |=> (ref_source_out == drcb_pkg::DRCB_SRC_PU);
    endproperty
    a_pu_wins: assert property (p_pu_wins) else $error("Per-unit reference not selected.");

    property p_hz_wins;
        (words_ff[drcb_pkg::IDX_FREQ_PU] == 16'h0000) && (words_ff[drcb_pkg::IDX_FREQ_HZ] != 16'h0000)
            |=> (ref_source_out == drcb_pkg::DRCB_SRC_HZ);
    endproperty
    a_hz_wins: assert property (p_hz_wins) else $error("Hundredth-hertz reference not selected.");

    property p_readback;
        (rd_code_in == drcb_pkg::CODE_FREQ_PU) && !wr_hit |=> (rd_data_out == $past(words_ff[drcb_pkg::IDX_FREQ_PU]));
    endproperty
    a_readback: assert property (p_readback) else $error("Readback differs from stored word.");

    property p_fclr_reads_zero;
        (rd_code_in == drcb_pkg::CODE_FCLR) |=> (rd_data_out == 16'h0000) && rd_hit_out;
    endproperty
    a_fclr_reads_zero: assert property (p_fclr_reads_zero) else $error("Fault clear word read nonzero.");

    property p_fclr_pulse;
        s_fclr_hit |=> fault_reset_out [*2];
    endproperty
    a_fclr_pulse: assert property (p_fclr_pulse) else $error("Fault reset not raised.");

    property p_alarm_reset;
        s_rst_fall |=> alarm_reset_out ##1 !alarm_reset_out;
    endproperty
    a_alarm_reset: assert property (p_alarm_reset) else $error("Run word alarm reset missing.");

    property p_no_reset_off_route;
        !link_active |=> !alarm_reset_out;
    endproperty
    a_no_reset_off_route: assert property (p_no_reset_off_route) else $error("Alarm reset off route.");

    property p_pu_clamp;
        $signed(applied_pu_out) <= $signed({1'b0, drcb_pkg::PU_FULL_SCALE});
    endproperty
    a_pu_clamp: assert property (p_pu_clamp) else $error("Applied per-unit above full scale.");

    property p_pu_linear;
        $stable(words_ff[drcb_pkg::IDX_FREQ_PU]) && (pu_limit_in >= drcb_pkg::PU_FULL_SCALE)
            && ($signed(words_ff[drcb_pkg::IDX_FREQ_PU]) >= 0)
            && (words_ff[drcb_pkg::IDX_FREQ_PU] <= drcb_pkg::PU_FULL_SCALE)
            |=> (applied_pu_out == $past(words_ff[drcb_pkg::IDX_FREQ_PU]));
    endproperty
    a_pu_linear: assert property (p_pu_linear) else $error("In-range per-unit altered.");

    property p_pid_neg;
        reduced_variant_in && words_ff[drcb_pkg::IDX_PID][15] |=> (applied_pid_out == 16'h0000);
    endproperty
    a_pid_neg: assert property (p_pid_neg) else $error("Negative PID not zeroed.");

    property p_store;
        wr_hit && !fclr_write |=> (words_ff[$past(wr_dec[3:0])] == $past(wr_data_in));
    endproperty
    a_store: assert property (p_store) else $error("Write not stored.");

endmodule

// [drcb_host_model.sv]
// Host controller model on the far side of the command word write port.
// Assumes one shared clock; each frame reaches the bank as a single pulse.
`timescale 1ns/10ps
module drcb_host_model (
    input wire logic clk_in,
    output logic wr_valid_out,
    output logic [4:0] wr_code_out,
    output logic [15:0] wr_data_out
);
    // ----------------------------------------------------------------
    // Idle state
    // ----------------------------------------------------------------
    initial begin
        wr_valid_out = 1'b0;
        wr_code_out = 5'h1f;
        wr_data_out = 16'h5a5a;
    end

    // ----------------------------------------------------------------
    // One validated frame per call
    // ----------------------------------------------------------------
    // Whole 16-bit words only; the bus shows the inverse once released so stale data never passes.
    task automatic send(input logic [4:0] code, input logic [15:0] data);
        @(posedge clk_in);
        wr_valid_out <= 1'b1;
        wr_code_out <= code;
        wr_data_out <= data;
        @(posedge clk_in);
        wr_valid_out <= 1'b0;
        wr_code_out <= ~code;
        wr_data_out <= ~data;
    endtask
endmodule

// [drcb_pkg.sv]
// Constants shared by the drive command register bank and its reference selector.
// Assumes a single 20 MHz system clock and a write-frame port that has already validated the frame.
package drcb_pkg;

    // ----------------------------------------------------------------
    // Command word codes on the write/read frame port
    // ----------------------------------------------------------------
    localparam logic [4:0] CODE_FREQ_PU = 5'h01;
    localparam logic [4:0] CODE_FREQ_HZ = 5'h05;
    localparam logic [4:0] CODE_RUN = 5'h06;
    localparam logic [4:0] CODE_DOUT = 5'h07;
    localparam logic [4:0] CODE_ACCEL = 5'h08;
    localparam logic [4:0] CODE_DECEL = 5'h09;
    localparam logic [4:0] CODE_TRQ1 = 5'h0a;
    localparam logic [4:0] CODE_TRQ2 = 5'h0b;
    localparam logic [4:0] CODE_AOUT = 5'h0c;
    localparam logic [4:0] CODE_PID = 5'h0d;
    localparam logic [4:0] CODE_FCLR = 5'h0e;
    localparam logic [4:0] CODE_SPEED = 5'h13;

    // ----------------------------------------------------------------
    // Storage layout and field positions
    // ----------------------------------------------------------------
    localparam int NWORDS = 12;
    localparam logic [3:0] IDX_FREQ_PU = 4'h0;
    localparam logic [3:0] IDX_FREQ_HZ = 4'h1;
    localparam logic [3:0] IDX_RUN = 4'h2;
    localparam logic [3:0] IDX_DOUT = 4'h3;
    localparam logic [3:0] IDX_ACCEL = 4'h4;
    localparam logic [3:0] IDX_DECEL = 4'h5;
    localparam logic [3:0] IDX_TRQ1 = 4'h6;
    localparam logic [3:0] IDX_TRQ2 = 4'h7;
    localparam logic [3:0] IDX_AOUT = 4'h8;
    localparam logic [3:0] IDX_PID = 4'h9;
    localparam logic [3:0] IDX_FCLR = 4'ha;
    localparam logic [3:0] IDX_SPEED = 4'hb;
    localparam int RUN_RST_BIT = 15;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] FCLR_ACTIVE = 16'h0001;
    localparam logic [15:0] PU_FULL_SCALE = 16'h4e20;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int FCLR_HOLD_MS = 10;
    localparam int FCLR_HOLD_CYCLES = FCLR_HOLD_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DRCB_SRC_NONE,
        DRCB_SRC_PU,
        DRCB_SRC_HZ,
        DRCB_SRC_SPEED
    } drcb_src_t;

endpackage

// [drcb_ref_if.sv]
// Interface carrying stored reference words to the selector and applied values back.
// Assumes both ends share the bank clock.
`timescale 1ns/10ps
interface drcb_ref_if;
    logic [15:0] freq_pu;
    logic [15:0] freq_hz;
    logic [15:0] speed;
    logic [15:0] pid;
    logic reduced;
    logic [15:0] pu_limit;
    logic [15:0] hz_limit;
    drcb_pkg::drcb_src_t src;
    logic [15:0] applied_pu;
    logic [15:0] applied_hz;
    logic [15:0] applied_speed;
    logic [15:0] applied_pid;

    modport bank (output freq_pu, freq_hz, speed, pid, reduced, pu_limit, hz_limit,
                  input src, applied_pu, applied_hz, applied_speed, applied_pid);
    modport sel (input freq_pu, freq_hz, speed, pid, reduced, pu_limit, hz_limit,
                 output src, applied_pu, applied_hz, applied_speed, applied_pid);
endinterface

// [drcb_ref_sel.sv]
// Reference precedence and limiting applied to the stored command words.
// Assumes the limits come from the drive's own configuration and are stable.
`timescale 1ns/10ps
module drcb_ref_sel (
    input wire logic clk_in,
    input wire logic nrst_in,
    drcb_ref_if.sel ref_if
);

    // ----------------------------------------------------------------
    // Precedence and clamping
    // ----------------------------------------------------------------
    logic [15:0] pu_lim;
    logic signed [16:0] pu_val;
    logic signed [16:0] pu_pos;
    logic signed [16:0] pu_neg;

    // The upper limit can only tighten the full-scale point, never widen it.
    assign pu_lim = (ref_if.pu_limit < drcb_pkg::PU_FULL_SCALE) ? ref_if.pu_limit : drcb_pkg::PU_FULL_SCALE;
    assign pu_val = {ref_if.freq_pu[15], ref_if.freq_pu};
    assign pu_pos = {1'b0, pu_lim};
    assign pu_neg = -pu_pos;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_if.src <= drcb_pkg::DRCB_SRC_NONE;
        end else if (ref_if.freq_pu != 16'h0000) begin
            ref_if.src <= drcb_pkg::DRCB_SRC_PU;
        end else if (ref_if.freq_hz != 16'h0000) begin
            ref_if.src <= drcb_pkg::DRCB_SRC_HZ;
        end else if (ref_if.speed != 16'h0000) begin
            ref_if.src <= drcb_pkg::DRCB_SRC_SPEED;
        end else begin
            ref_if.src <= drcb_pkg::DRCB_SRC_NONE;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_if.applied_pu <= 16'h0000;
            ref_if.applied_hz <= 16'h0000;
        end else begin
            if (pu_val > pu_pos) begin
                ref_if.applied_pu <= pu_lim;
            end else if (pu_val < pu_neg) begin
                ref_if.applied_pu <= pu_neg[15:0];
            end else begin
                ref_if.applied_pu <= ref_if.freq_pu;
            end
            ref_if.applied_hz <= (ref_if.freq_hz > ref_if.hz_limit) ? ref_if.hz_limit : ref_if.freq_hz;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_if.applied_speed <= 16'h0000;
            ref_if.applied_pid <= 16'h0000;
        end else begin
            ref_if.applied_speed <= ref_if.speed;
            ref_if.applied_pid <= (ref_if.reduced && ref_if.pid[15]) ? 16'h0000 : ref_if.pid;
        end
    end

endmodule

// [tb.sv]
// Self-checking bench for the drive command register bank.
// Assumes the host model drives writes; the bench drives reads, route inputs and limits.
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [4:0] rd_code_in = 5'h00;
    logic route = 1'b0;
    logic enable = 1'b0;
    logic reduced = 1'b0;
    logic [15:0] pu_lim = 16'hffff;
    logic [15:0] hz_lim = 16'hffff;
    logic wr_valid;
    logic [4:0] wr_code;
    logic [15:0] wr_data;
    logic [15:0] rd_data_out, run_w, dout_w, aout_w, ap_pu, ap_hz, ap_sp, ap_pid;
    logic rd_hit_out, alarm_rst, fault_rst;
    drcb_pkg::drcb_src_t src;
    int fail_count = 0;
    int check_count = 0;
    logic [4:0] codes [0:11] = '{drcb_pkg::CODE_FREQ_PU, drcb_pkg::CODE_FREQ_HZ, drcb_pkg::CODE_RUN,
        drcb_pkg::CODE_DOUT, drcb_pkg::CODE_ACCEL, drcb_pkg::CODE_DECEL, drcb_pkg::CODE_TRQ1,
        drcb_pkg::CODE_TRQ2, drcb_pkg::CODE_AOUT, drcb_pkg::CODE_PID, drcb_pkg::CODE_FCLR, drcb_pkg::CODE_SPEED};

    always #25 clk_in = ~clk_in;

    drcb_host_model host (.clk_in(clk_in), .wr_valid_out(wr_valid), .wr_code_out(wr_code), .wr_data_out(wr_data));

    // A short hold keeps the fault clear test quick; expectations use the same figure.
    localparam int HOLD = 8;
    drcb_bank #(.FCLR_HOLD_CYCLES(HOLD)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .wr_valid_in(wr_valid),
        .wr_code_in(wr_code), .wr_data_in(wr_data), .rd_code_in(rd_code_in), .link_route_select_in(route),
        .link_enable_input_in(enable), .reduced_variant_in(reduced), .pu_limit_in(pu_lim), .hz_limit_in(hz_lim),
        .rd_data_out(rd_data_out), .rd_hit_out(rd_hit_out), .run_word_out(run_w), .digital_out_out(dout_w),
        .analog_out_out(aout_w), .alarm_reset_out(alarm_rst), .fault_reset_out(fault_rst),
        .ref_source_out(src), .applied_pu_out(ap_pu), .applied_hz_out(ap_hz),
        .applied_speed_out(ap_sp), .applied_pid_out(ap_pid));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [4:0] code, input logic [15:0] exp, input logic hit);
        @(posedge clk_in);
        rd_code_in <= code;
        @(posedge clk_in);
        #1;
        check(rd_data_out, exp);
        check({15'h0, rd_hit_out}, {15'h0, hit});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic src_is(input drcb_pkg::drcb_src_t exp);
        check({14'h0, src}, {14'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_map();
        for (int i = 0; i < 12; i++) rd(codes[i], 16'h0000, 1'b1);
        for (int i = 0; i < 12; i++) host.send(codes[i], 16'h1200 + 16'(i));
        host.send(5'h02, 16'hbeef);
        for (int i = 0; i < 12; i++) rd(codes[i], (i == 10) ? 16'h0000 : 16'h1200 + 16'(i), 1'b1);
        rd(5'h02, 16'h0000, 1'b0);
        check(run_w, 16'h1202);
        check(dout_w, 16'h1203);
        check(aout_w, 16'h1208);
        check({15'h0, fault_rst}, 16'h0000);
        $display("test map done");
    endtask

    task automatic t_precedence();
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h2710);
        host.send(drcb_pkg::CODE_FREQ_HZ, 16'h1770);
        host.send(drcb_pkg::CODE_SPEED, 16'h05dc);
        settle();
        src_is(drcb_pkg::DRCB_SRC_PU);
        check(ap_pu, 16'h2710);
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h0000);
        settle();
        src_is(drcb_pkg::DRCB_SRC_HZ);
        check(ap_hz, 16'h1770);
        host.send(drcb_pkg::CODE_FREQ_HZ, 16'h0000);
        settle();
        src_is(drcb_pkg::DRCB_SRC_SPEED);
        check(ap_sp, 16'h05dc);
        host.send(drcb_pkg::CODE_SPEED, 16'h0000);
        settle();
        src_is(drcb_pkg::DRCB_SRC_NONE);
        $display("test precedence done");
    endtask

    task automatic t_clamp();
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h61a8);
        settle();
        check(ap_pu, drcb_pkg::PU_FULL_SCALE);
        rd(drcb_pkg::CODE_FREQ_PU, 16'h61a8, 1'b1);
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h9e58);
        settle();
        check(ap_pu, 16'hb1e0);
        @(posedge clk_in);
        pu_lim <= 16'h2710;
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h4e20);
        settle();
        check(ap_pu, 16'h2710);
        host.send(drcb_pkg::CODE_FREQ_PU, 16'h0000);
        @(posedge clk_in);
        hz_lim <= 16'h1770;
        host.send(drcb_pkg::CODE_FREQ_HZ, 16'hffff);
        settle();
        check(ap_hz, 16'h1770);
        rd(drcb_pkg::CODE_FREQ_HZ, 16'hffff, 1'b1);
        $display("test clamp done");
    endtask

    task automatic t_pid();
        @(posedge clk_in);
        reduced <= 1'b1;
        host.send(drcb_pkg::CODE_PID, 16'h8000);
        settle();
        check(ap_pid, 16'h0000);
        rd(drcb_pkg::CODE_PID, 16'h8000, 1'b1);
        @(posedge clk_in);
        reduced <= 1'b0;
        settle();
        check(ap_pid, 16'h8000);
        $display("test pid done");
    endtask

    // With either route input low the set-then-clear sequence must do nothing.
    // The pulse stands for the one cycle after the clearing write, so it is looked at right away.
    task automatic alarm_seq(input logic on, input logic en, input logic exp);
        @(posedge clk_in);
        route <= on;
        enable <= en;
        host.send(drcb_pkg::CODE_RUN, 16'h8000);
        host.send(drcb_pkg::CODE_RUN, 16'h0000);
        #1;
        check({15'h0, alarm_rst}, {15'h0, exp});
        @(posedge clk_in);
        #1;
        check({15'h0, alarm_rst}, 16'h0000);
    endtask

    task automatic t_alarm();
        alarm_seq(1'b0, 1'b1, 1'b0);
        alarm_seq(1'b1, 1'b0, 1'b0);
        alarm_seq(1'b1, 1'b1, 1'b1);
        $display("test alarm done");
    endtask

    task automatic t_fault();
        int n;
        n = 0;
        @(posedge clk_in);
        route <= 1'b0;
        enable <= 1'b0;
        host.send(drcb_pkg::CODE_FCLR, 16'h0001);
        #1;
        check({15'h0, fault_rst}, 16'h0001);
        while (fault_rst === 1'b1 && n < 30) begin
            n++;
            @(posedge clk_in);
            #1;
        end
        check(16'(n), 16'(HOLD));
        rd(drcb_pkg::CODE_FCLR, 16'h0000, 1'b1);
        $display("test fault done");
    endtask

    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_reset_and_map();
        t_precedence();
        t_clamp();
        t_pid();
        t_alarm();
        t_fault();
        stop_test();
    end

    // The whole run needs well under a thousand cycles; five thousand means a hang.
    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        stop_test();
    end
endmodule
